// ===== src/tuning_defs.svh
`ifndef TUNING_DEFS_SVH
`define TUNING_DEFS_SVH

// value ranges of the write messages
`define GAIN_MAX 16'h7FFF
`define PERCENT_MAX 16'h0064
`define SOFT_MIN 16'h0001
`define SOFT_MAX 16'h03E8
`define SOFT_DEFAULT 15'h03E8
`define SWITCH_MAX 16'h0003
`define SETPT_MAX 16'h2710
`define INDEX_MIN 8'h01
`define INDEX_SP_MAX 8'h05
`define INDEX_OPEN 8'h07
`define INDEX_CLOSE 8'h08

// request codes
`define KP_Q_FIRST 8'h2E
`define KP_Q_LAST 8'h32
`define KI_Q_FIRST 8'h29
`define KI_Q_LAST 8'h2D
`define SOFT_Q_FIRST 8'h0F
`define SOFT_Q_LAST 8'h13
`define SOFT_Q_OPEN 8'h15
`define SOFT_Q_CLOSE 8'h16

// storage slots: five proportional, five integral, seven softstart
`define SLOT_KP 5'h00
`define SLOT_KI 5'h05
`define SLOT_SOFT 5'h0A
`define SLOT_OPEN 5'h0F
`define SLOT_CLOSE 5'h10
`define SLOT_COUNT 17

// reset values
`define PERCENT_RESET 7'h64
`define RATE_RESET 16'h0001

// control cycle
`define CLK_PERIOD_NS 8
`define CTRL_CYCLE_NS 1000000
`define CTRL_CYCLES (`CTRL_CYCLE_NS / `CLK_PERIOD_NS)

`endif

// ===== src/tuning_pkg.sv
package tuning_pkg;

	typedef enum logic [3:0] {
		OP_KP_WR = 4'h0,
		OP_KI_WR = 4'h1,
		OP_SOFT_WR = 4'h2,
		OP_PCOMP_WR = 4'h3,
		OP_ICOMP_WR = 4'h4,
		OP_RATE_WR = 4'h5,
		OP_SWITCH_WR = 4'h6,
		OP_SETPT_WR = 4'h7,
		OP_CODE_Q = 4'h8,
		OP_PCOMP_Q = 4'h9,
		OP_ICOMP_Q = 4'hA,
		OP_RATE_Q = 4'hB,
		OP_SWITCH_Q = 4'hC
	} opcode_e;

	typedef struct packed {
		opcode_e op;
		logic [7:0] index;
		logic [15:0] value;
	} message_s;

	typedef enum logic [1:0] {
		RAMP_OFF = 2'h0,
		RAMP_BOTH = 2'h1,
		RAMP_DOWN = 2'h2,
		RAMP_UP = 2'h3
	} ramp_mode_e;

	typedef enum logic [1:0] {
		SENSE_HIGH = 2'h0,
		SENSE_LOW = 2'h1,
		SENSE_AUTO = 2'h2
	} sensor_mode_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_READ = 1'b1
	} parse_state_e;

endpackage

// ===== src/slot_mem.sv
`timescale 1ns/1ps
// small storage with one write port and two registered read ports
module slot_mem #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 17,
	parameter int AW = 5,
	parameter int DEFAULT_FROM = 10,
	parameter logic [WIDTH-1:0] DEFAULT_VAL = '0
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_a_addr_in,
	output logic [WIDTH-1:0] rd_a_data_out,
	input wire logic [AW-1:0] rd_b_addr_in,
	output logic [WIDTH-1:0] rd_b_data_out
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0] rd_a;
		logic [WIDTH-1:0] rd_b;
	} mem_state_s;

	mem_state_s state_reg;
	mem_state_s state_next;

	always_comb begin
		state_next = state_reg;
		if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
			state_next.words[wr_addr_in] = wr_data_in;
		end
		state_next.rd_a = (int'(rd_a_addr_in) < DEPTH) ? state_reg.words[rd_a_addr_in] : '0;
		state_next.rd_b = (int'(rd_b_addr_in) < DEPTH) ? state_reg.words[rd_b_addr_in] : '0;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				state_reg.words[i] <= (i >= DEFAULT_FROM) ? DEFAULT_VAL : '0;
			end
			state_reg.rd_a <= '0;
			state_reg.rd_b <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_a_data_out = state_reg.rd_a;
	assign rd_b_data_out = state_reg.rd_b;
endmodule

// ===== src/tuning_parser.sv
`timescale 1ns/1ps
`include "tuning_defs.svh"
// Overview of operation
// R1: proportional gain write, index 1-5, value 0-32767, stored per setpoint.
// R2: request codes 46-50 answer with proportional gain in write format.
// R3: high-range setpoints use stored gain, low-range ones scale it by percentage.
// R4: proportional compensation percentage 0-100 write, request echoes it.
// R5: integral gain write, index 1-5, value 0-32767, stored per setpoint.
// R6: request codes 41-45 answer with integral gain in write format.
// R7: low-range setpoints scale integral gain by its compensation percentage.
// R8: integral compensation percentage 0-100 write, request echoes it.
// R9: softstart write takes index 1-5, 7 open, 8 close, 0.1-100 percent.
// R10: codes 15-19, 21, 22 answer softstart rates in write format.
// R11: every softstart rate defaults to 100 percent of full speed.
// R12: gradual ramp acts only under PID control, never under model-based control.
// R13: while ramping, working setpoint moves toward target at programmed rate.
// R14: ramp rate write must be positive; zero is refused.
// R15: ramp switch: 0 off, 1 both ways, 2 falling only, 3 rising only.
// R16: ramp off means the working setpoint jumps straight to the target.
// R17: setpoint entries are taken the same way whether ramping or not.
// R18: setpoint is percent of active sensor, or high sensor in auto dual mode.
// R19: on enable or new setpoint, compare pressure and step each control cycle.
// R20: requests return the stored ramp rate and ramp switch setting.
// R21: writes with index or value out of range are ignored.
// R22: each parameter has its own slot, changed only by its own write.
module tuning_parser
	import tuning_pkg::*;
#(
	parameter int CTRL_CYCLES = `CTRL_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire message_s cmd_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output message_s rsp_out,
	input wire logic model_based_select_in,
	input wire sensor_mode_e sensor_mode_in,
	input wire logic [2:0] active_setpoint_in,
	input wire logic low_range_in,
	input wire logic [15:0] pressure_in,
	output logic [14:0] proportional_gain_out,
	output logic [14:0] integral_gain_out,
	output logic [15:0] working_setpoint_out,
	output logic ramp_active_out,
	output logic sensor_low_scale_out
);
	localparam int TW = $clog2(CTRL_CYCLES + 1);

	typedef struct packed {
		parse_state_e st;
		message_s rsp;
		logic rsp_valid;
		logic [6:0] prop_low_range_percent;
		logic [6:0] integ_low_range_percent;
		logic [15:0] rate;
		ramp_mode_e rmode;
		logic [15:0] target;
		logic [15:0] working;
		logic ramping;
		logic ramp_up;
		logic [TW-1:0] tick_cnt;
		logic live_phase;
		logic [14:0] kp_live;
		logic [14:0] ki_live;
		logic [14:0] kp_eff;
		logic [14:0] ki_eff;
		logic sensor_low;
	} parser_state_s;

	parser_state_s state_reg;
	parser_state_s state_next;

	logic accept;
	logic tick_now;
	logic eval_now;
	logic mem_wr;
	logic [4:0] mem_wr_addr;
	logic [4:0] mem_rd_addr;
	logic [4:0] live_addr;
	logic [14:0] mem_rd_data;
	logic [14:0] live_data;

	////////////////////////////////////////////////////////////////////////////
	// slot decoding, shared by writes and requests
	function automatic logic [5:0] slot_of(input opcode_e op, input logic [7:0] idx);
		logic sp_ok;
		sp_ok = idx >= `INDEX_MIN && idx <= `INDEX_SP_MAX;
		slot_of = 6'h00;
		unique case (op)
			OP_KP_WR: slot_of = {sp_ok, `SLOT_KP + 5'(idx - `INDEX_MIN)}; // R22
			OP_KI_WR: slot_of = {sp_ok, `SLOT_KI + 5'(idx - `INDEX_MIN)}; // R22
			OP_SOFT_WR: begin
				if (idx == `INDEX_OPEN) begin
					slot_of = {1'b1, `SLOT_OPEN}; // R9
				end else if (idx == `INDEX_CLOSE) begin
					slot_of = {1'b1, `SLOT_CLOSE}; // R9
				end else begin
					slot_of = {sp_ok, `SLOT_SOFT + 5'(idx - `INDEX_MIN)}; // R9
				end
			end
			default: slot_of = 6'h00;
		endcase
	endfunction

	// request code to the echo opcode and index; top bit marks a known code
	function automatic logic [12:0] code_map(input logic [7:0] code);
		code_map = 13'h0000;
		if (code >= `KP_Q_FIRST && code <= `KP_Q_LAST) begin
			code_map = {1'b1, OP_KP_WR, 8'(code - `KP_Q_FIRST + `INDEX_MIN)}; // R2
		end else if (code >= `KI_Q_FIRST && code <= `KI_Q_LAST) begin
			code_map = {1'b1, OP_KI_WR, 8'(code - `KI_Q_FIRST + `INDEX_MIN)}; // R6
		end else if (code >= `SOFT_Q_FIRST && code <= `SOFT_Q_LAST) begin
			code_map = {1'b1, OP_SOFT_WR, 8'(code - `SOFT_Q_FIRST + `INDEX_MIN)}; // R10
		end else if (code == `SOFT_Q_OPEN) begin
			code_map = {1'b1, OP_SOFT_WR, `INDEX_OPEN}; // R10
		end else if (code == `SOFT_Q_CLOSE) begin
			code_map = {1'b1, OP_SOFT_WR, `INDEX_CLOSE}; // R10
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	slot_mem #(
		.WIDTH(15),
		.DEPTH(`SLOT_COUNT),
		.AW(5),
		.DEFAULT_FROM(int'(`SLOT_SOFT)),
		.DEFAULT_VAL(`SOFT_DEFAULT) // R11
	) u_slots (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.wr_en_in(mem_wr),
		.wr_addr_in(mem_wr_addr),
		.wr_data_in(cmd_in.value[14:0]),
		.rd_a_addr_in(mem_rd_addr),
		.rd_a_data_out(mem_rd_data),
		.rd_b_addr_in(live_addr),
		.rd_b_data_out(live_data)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [5:0] wslot;
		logic [12:0] qmap;
		logic [5:0] qslot;
		logic [21:0] kp_prod;
		logic [21:0] ki_prod;
		logic [15:0] gap;
		logic want_up;
		logic allowed;
		logic ramp_on;
		wslot = slot_of(cmd_in.op, cmd_in.index);
		qmap = code_map(cmd_in.index);
		qslot = slot_of(opcode_e'(qmap[11:8]), qmap[7:0]);
		kp_prod = 22'(state_reg.kp_live * state_reg.prop_low_range_percent);
		ki_prod = 22'(state_reg.ki_live * state_reg.integ_low_range_percent);
		gap = 16'h0000;
		want_up = 1'b0;
		allowed = 1'b0;
		ramp_on = 1'b0;
		state_next = state_reg;
		state_next.rsp_valid = 1'b0;
		accept = cmd_valid_in && state_reg.st == ST_IDLE;
		mem_wr = 1'b0;
		mem_wr_addr = wslot[4:0];
		mem_rd_addr = qslot[4:0];
		eval_now = 1'b0;

		// request and write handling
		unique case (state_reg.st)
			ST_IDLE: begin
				if (accept) begin
					unique case (cmd_in.op)
						OP_KP_WR, OP_KI_WR: begin
							mem_wr = wslot[5] && cmd_in.value <= `GAIN_MAX; // R1 R5 R21
						end
						OP_SOFT_WR: begin
							mem_wr = wslot[5] && cmd_in.value >= `SOFT_MIN && cmd_in.value <= `SOFT_MAX; // R9 R21
						end
						OP_PCOMP_WR: begin
							if (cmd_in.value <= `PERCENT_MAX) begin // R4 R21
								state_next.prop_low_range_percent = cmd_in.value[6:0];
							end
						end
						OP_ICOMP_WR: begin
							if (cmd_in.value <= `PERCENT_MAX) begin // R8 R21
								state_next.integ_low_range_percent = cmd_in.value[6:0];
							end
						end
						OP_RATE_WR: begin
							if (cmd_in.value != 16'h0000) begin // R14
								state_next.rate = cmd_in.value;
							end
						end
						OP_SWITCH_WR: begin
							if (cmd_in.value <= `SWITCH_MAX) begin // R15 R21
								state_next.rmode = ramp_mode_e'(cmd_in.value[1:0]);
								eval_now = state_reg.rmode == RAMP_OFF && cmd_in.value != 16'h0000; // R19
							end
						end
						OP_SETPT_WR: begin
							// same acceptance whatever the ramp setting
							if (cmd_in.index >= `INDEX_MIN && cmd_in.index <= `INDEX_SP_MAX &&
								cmd_in.value <= `SETPT_MAX) begin // R17 R21
								state_next.target = cmd_in.value;
								eval_now = 1'b1; // R19
							end
						end
						OP_CODE_Q: begin
							if (qmap[12]) begin
								state_next.rsp = '{op: opcode_e'(qmap[11:8]), index: qmap[7:0], value: 16'h0000};
								state_next.st = ST_READ;
							end
						end
						OP_PCOMP_Q, OP_ICOMP_Q, OP_RATE_Q, OP_SWITCH_Q: begin
							state_next.rsp = '{op: cmd_in.op, index: 8'h00, value: 16'h0000};
							state_next.st = ST_READ;
						end
						default: begin
						end
					endcase
				end
			end
			ST_READ: begin
				// answers reuse the write opcode so the host sees the echo format
				unique case (state_reg.rsp.op)
					OP_PCOMP_Q: begin
						state_next.rsp.op = OP_PCOMP_WR;
						state_next.rsp.value = {9'h000, state_reg.prop_low_range_percent}; // R4
					end
					OP_ICOMP_Q: begin
						state_next.rsp.op = OP_ICOMP_WR;
						state_next.rsp.value = {9'h000, state_reg.integ_low_range_percent}; // R8
					end
					OP_RATE_Q: begin
						state_next.rsp.op = OP_RATE_WR;
						state_next.rsp.value = state_reg.rate; // R20
					end
					OP_SWITCH_Q: begin
						state_next.rsp.op = OP_SWITCH_WR;
						state_next.rsp.value = {14'h0000, state_reg.rmode}; // R20
					end
					default: state_next.rsp.value = {1'b0, mem_rd_data}; // R2 R6 R10
				endcase
				state_next.rsp_valid = 1'b1;
				state_next.st = ST_IDLE;
			end
		endcase

		// live gains: one slot port alternates between the two gains
		live_addr = (state_reg.live_phase ? `SLOT_KI : `SLOT_KP) +
			((active_setpoint_in <= 3'h4) ? {2'h0, active_setpoint_in} : 5'h00);
		state_next.live_phase = !state_reg.live_phase;
		if (state_reg.live_phase) begin
			state_next.kp_live = live_data;
		end else begin
			state_next.ki_live = live_data;
		end
		state_next.kp_eff = low_range_in ? 15'(kp_prod / 22'h00_0064) : state_reg.kp_live; // R3
		state_next.ki_eff = low_range_in ? 15'(ki_prod / 22'h00_0064) : state_reg.ki_live; // R7
		state_next.sensor_low = sensor_mode_in == SENSE_LOW; // R18

		// control cycle divider
		tick_now = state_reg.tick_cnt == TW'(CTRL_CYCLES - 1);
		state_next.tick_cnt = tick_now ? '0 : state_reg.tick_cnt + 1'b1;

		// gradual ramp
		ramp_on = state_next.rmode != RAMP_OFF && !model_based_select_in; // R12
		if (!ramp_on) begin
			state_next.working = state_next.target; // R12 R16
			state_next.ramping = 1'b0;
		end else if (eval_now) begin
			want_up = pressure_in < state_next.target; // R19
			allowed = state_next.rmode == RAMP_BOTH || (state_next.rmode == RAMP_UP && want_up) ||
				(state_next.rmode == RAMP_DOWN && !want_up); // R15
			state_next.ramp_up = want_up;
			state_next.ramping = allowed && pressure_in != state_next.target;
			state_next.working = state_next.ramping ? pressure_in : state_next.target;
		end else if (state_reg.ramping && tick_now) begin
			gap = state_reg.ramp_up ? state_reg.target - state_reg.working : state_reg.working - state_reg.target;
			if (gap <= state_reg.rate) begin
				state_next.working = state_reg.target; // R13
				state_next.ramping = 1'b0;
			end else begin
				state_next.working = state_reg.ramp_up ? state_reg.working + state_reg.rate :
					state_reg.working - state_reg.rate; // R13 R19
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_reg <= '0;
			state_reg.prop_low_range_percent <= `PERCENT_RESET;
			state_reg.integ_low_range_percent <= `PERCENT_RESET;
			state_reg.rate <= `RATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cmd_ready_out = state_reg.st == ST_IDLE;
	assign rsp_valid_out = state_reg.rsp_valid;
	assign rsp_out = state_reg.rsp;
	assign proportional_gain_out = state_reg.kp_eff;
	assign integral_gain_out = state_reg.ki_eff;
	assign working_setpoint_out = state_reg.working;
	assign ramp_active_out = state_reg.ramping;
	assign sensor_low_scale_out = state_reg.sensor_low;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_kp_query;
		accept && cmd_in.op == OP_CODE_Q && cmd_in.index >= `KP_Q_FIRST && cmd_in.index <= `KP_Q_LAST;
	endsequence
	sequence s_ki_query;
		accept && cmd_in.op == OP_CODE_Q && cmd_in.index >= `KI_Q_FIRST && cmd_in.index <= `KI_Q_LAST;
	endsequence

	a_kp_query_reply: assert property (s_kp_query |=> !cmd_ready_out ##1 // R2
		(rsp_valid_out && rsp_out.op == OP_KP_WR && rsp_out.index == $past(cmd_in.index, 2) - `KP_Q_FIRST + 8'h01))
		else $error("proportional gain request not answered in echo form");
	a_ki_query_reply: assert property (s_ki_query |-> ##2 (rsp_valid_out && rsp_out.op == OP_KI_WR)) // R6
		else $error("integral gain request not answered in echo form");
	// a new request may already be taken in the reply cycle, so ready is checked there
	a_reply_pulse: assert property (rsp_valid_out |-> cmd_ready_out ##1 !rsp_valid_out) // R2
		else $error("reply valid held longer than one cycle");
	a_pcomp_range: assert property (accept && cmd_in.op == OP_PCOMP_WR && cmd_in.value > `PERCENT_MAX // R21
		|=> $stable(state_reg.prop_low_range_percent))
		else $error("out of range percentage was stored");
	a_rate_nonzero: assert property (accept && cmd_in.op == OP_RATE_WR && cmd_in.value == 16'h0000 // R14
		|=> $stable(state_reg.rate))
		else $error("zero ramp rate was stored");
	a_switch_range: assert property (accept && cmd_in.op == OP_SWITCH_WR && cmd_in.value > `SWITCH_MAX // R15
		|=> $stable(state_reg.rmode))
		else $error("out of range ramp switch was stored");
	a_model_direct: assert property (model_based_select_in |=> working_setpoint_out == state_reg.target) // R12
		else $error("ramp acted under model-based control");
	a_off_direct: assert property (state_reg.rmode == RAMP_OFF && !(accept && cmd_in.op == OP_SWITCH_WR) // R16
		|=> working_setpoint_out == state_reg.target && !ramp_active_out)
		else $error("working setpoint lags target with ramp off");
	a_ramp_step: assert property (state_reg.ramping && state_reg.ramp_up && tick_now && !eval_now && // R13
		!model_based_select_in && !(accept && cmd_in.op == OP_SWITCH_WR) &&
		state_reg.target - state_reg.working > state_reg.rate
		|=> working_setpoint_out == $past(state_reg.working) + $past(state_reg.rate))
		else $error("ramp step differs from programmed rate");
	a_ramp_hold: assert property (state_reg.ramping && !tick_now && !eval_now && !model_based_select_in && // R19
		!(accept && cmd_in.op == OP_SWITCH_WR) |=> $stable(working_setpoint_out))
		else $error("working setpoint moved between control cycles");
endmodule

// ===== testbench/host_model.sv
`timescale 1ns/1ps
// host side of the command port: one request at a time, held until ready is seen
module host_model
	import tuning_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic cmd_ready_in,
	output logic cmd_valid_out,
	output message_s cmd_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_out = '0;
	end

	////////////////////////////////////////////////////////////
	// rate writes of zero are only sent by scenarios that expect a refusal
	task automatic send(input message_s msg);
		@(posedge sys_clk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_out = msg;
		do @(posedge sys_clk_in);
		while (cmd_ready_in !== 1'b1);
		#1;
		cmd_valid_out = 1'b0;
		// a released bus must not look like a stable copy of the last command
		cmd_out = message_s'(~msg);
	endtask
endmodule

// ===== testbench/tuning_parser_tb.sv
`timescale 1ns/1ps
module tuning_parser_tb;
	import tuning_pkg::*;
	typedef struct packed {
		message_s wr;
		opcode_e qop;
		logic [7:0] qi;
		logic [15:0] ev;
	} row_s;
	localparam int CYC = 8;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid;
	message_s cmd;
	logic cmd_ready;
	logic rsp_valid;
	message_s rsp;
	logic model_sel = 1'b0;
	sensor_mode_e sensor_mode = SENSE_HIGH;
	logic [2:0] active_sp = 3'h0;
	logic low_range = 1'b0;
	logic [15:0] pressure = 16'h0000;
	logic [14:0] kp_eff;
	logic [14:0] ki_eff;
	logic [15:0] working;
	logic ramping;
	logic low_scale;
	int err_total = 0;
	int checks = 0;
	// write, then the query that reads it back, then the value the reply must carry
	row_s rows [18] = '{
		'{'{OP_KP_WR, 8'h01, 16'h0032}, OP_CODE_Q, 8'h2E, 16'h0032},
		'{'{OP_KP_WR, 8'h05, 16'h7FFF}, OP_CODE_Q, 8'h32, 16'h7FFF},
		'{'{OP_KP_WR, 8'h01, 16'h8000}, OP_CODE_Q, 8'h2E, 16'h0032},
		'{'{OP_KI_WR, 8'h01, 16'h0005}, OP_CODE_Q, 8'h29, 16'h0005},
		'{'{OP_KI_WR, 8'h05, 16'h000A}, OP_CODE_Q, 8'h2D, 16'h000A},
		'{'{OP_SOFT_WR, 8'h07, 16'h01F4}, OP_CODE_Q, 8'h15, 16'h01F4},
		'{'{OP_SOFT_WR, 8'h08, 16'h0001}, OP_CODE_Q, 8'h16, 16'h0001},
		'{'{OP_SOFT_WR, 8'h03, 16'h00FA}, OP_CODE_Q, 8'h11, 16'h00FA},
		'{'{OP_SOFT_WR, 8'h07, 16'h0000}, OP_CODE_Q, 8'h15, 16'h01F4},
		'{'{OP_PCOMP_WR, 8'h00, 16'h0050}, OP_PCOMP_Q, 8'h00, 16'h0050},
		'{'{OP_PCOMP_WR, 8'h00, 16'h0065}, OP_PCOMP_Q, 8'h00, 16'h0050},
		'{'{OP_ICOMP_WR, 8'h00, 16'h0000}, OP_ICOMP_Q, 8'h00, 16'h0000},
		'{'{OP_RATE_WR, 8'h00, 16'h0004}, OP_RATE_Q, 8'h00, 16'h0004},
		'{'{OP_RATE_WR, 8'h00, 16'h0000}, OP_RATE_Q, 8'h00, 16'h0004},
		'{'{OP_SWITCH_WR, 8'h00, 16'h0002}, OP_SWITCH_Q, 8'h00, 16'h0002},
		'{'{OP_SWITCH_WR, 8'h00, 16'h0004}, OP_SWITCH_Q, 8'h00, 16'h0002},
		'{'{OP_SWITCH_WR, 8'h00, 16'h0003}, OP_SWITCH_Q, 8'h00, 16'h0003},
		'{'{OP_SWITCH_WR, 8'h00, 16'h0000}, OP_SWITCH_Q, 8'h00, 16'h0000}
	};

	always #4 sys_clk = ~sys_clk;

	host_model host (
		.sys_clk_in(sys_clk),
		.cmd_ready_in(cmd_ready),
		.cmd_valid_out(cmd_valid),
		.cmd_out(cmd)
	);

	tuning_parser #(.CTRL_CYCLES(CYC)) dut (
		.sys_clk_in(sys_clk),
		.rst_in(rst),
		.cmd_valid_in(cmd_valid),
		.cmd_in(cmd),
		.cmd_ready_out(cmd_ready),
		.rsp_valid_out(rsp_valid),
		.rsp_out(rsp),
		.model_based_select_in(model_sel),
		.sensor_mode_in(sensor_mode),
		.active_setpoint_in(active_sp),
		.low_range_in(low_range),
		.pressure_in(pressure),
		.proportional_gain_out(kp_eff),
		.integral_gain_out(ki_eff),
		.working_setpoint_out(working),
		.ramp_active_out(ramping),
		.sensor_low_scale_out(low_scale)
	);

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic ask(input message_s q, input message_s exp);
		int i;
		host.send(q);
		for (i = 1; i < 5; i++) begin
			tick(1);
			if (rsp_valid === 1'b1) break;
		end
		// send returns just after the accepting edge; the pulse shows after the next edge
		chk(28'(i), 28'h000_0001);
		chk(rsp, exp);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// the whole run is about 300 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		wrap_up();
	end

	initial begin
		int n;
		int k;
		tick(8);
		rst = 1'b0;
		chk(28'(cmd_ready), 28'h000_0001);
		foreach (rows[r]) begin
			host.send(rows[r].wr);
			ask('{rows[r].qop, rows[r].qi, 16'h0000}, '{rows[r].wr.op, rows[r].wr.index, rows[r].ev});
		end
		host.send('{OP_KP_WR, 8'h01, 16'h005A});
		host.send('{OP_KI_WR, 8'h01, 16'h0014});
		host.send('{OP_PCOMP_WR, 8'h00, 16'h0032});
		host.send('{OP_ICOMP_WR, 8'h00, 16'h004B});
		low_range = 1'b1;
		tick(6);
		chk(28'(kp_eff), 28'h000_002D);
		chk(28'(ki_eff), 28'h000_000F);
		low_range = 1'b0;
		tick(6);
		chk(28'(kp_eff), 28'h000_005A);
		chk(28'(ki_eff), 28'h000_0014);
		active_sp = 3'h4;
		tick(6);
		chk(28'(kp_eff), 28'h000_7FFF);
		chk(28'(ki_eff), 28'h000_000A);
		active_sp = 3'h0;
		sensor_mode = SENSE_LOW;
		tick(2);
		chk(28'(low_scale), 28'h000_0001);
		sensor_mode = SENSE_AUTO;
		tick(2);
		chk(28'(low_scale), 28'h000_0000);
		// ramp off: target taken at once
		host.send('{OP_SETPT_WR, 8'h01, 16'h03E8});
		tick(2);
		chk(28'({ramping, working}), 28'h000_03E8);
		pressure = 16'h03E8;
		host.send('{OP_SWITCH_WR, 8'h00, 16'h0001});
		host.send('{OP_SETPT_WR, 8'h01, 16'h0410});
		tick(2);
		chk(28'(ramping), 28'h000_0001);
		chk(28'(working < 16'h0410), 28'h000_0001);
		n = 0;
		while (ramping === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		// ten steps of four, one step per control cycle of eight clocks
		chk(28'(n >= 70 && n < 100), 28'h000_0001);
		chk(28'({ramping, working}), 28'h000_0410);
		host.send('{OP_SWITCH_WR, 8'h00, 16'h0003});
		pressure = 16'h0500;
		host.send('{OP_SETPT_WR, 8'h02, 16'h0400});
		tick(2);
		chk(28'({ramping, working}), 28'h000_0400);
		host.send('{OP_SETPT_WR, 8'h02, 16'h0600});
		tick(2);
		chk(28'(ramping), 28'h000_0001);
		host.send('{OP_SWITCH_WR, 8'h00, 16'h0000});
		tick(2);
		chk(28'({ramping, working}), 28'h000_0600);
		model_sel = 1'b1;
		host.send('{OP_SWITCH_WR, 8'h00, 16'h0001});
		host.send('{OP_SETPT_WR, 8'h01, 16'h0200});
		tick(2);
		chk(28'({ramping, working}), 28'h000_0200);
		model_sel = 1'b0;
		host.send('{OP_SETPT_WR, 8'h01, 16'h2711});
		host.send('{OP_SETPT_WR, 8'h06, 16'h0100});
		tick(2);
		chk(28'(working), 28'h000_0200);
		// second reset in mid-run brings every softstart rate back to full speed
		rst = 1'b1;
		tick(8);
		rst = 1'b0;
		for (k = 0; k < 7; k++) begin
			ask('{OP_CODE_Q, 8'(k < 5 ? k + 15 : k + 16), 16'h0000}, '{OP_SOFT_WR, 8'(k < 5 ? k + 1 : k + 2), 16'h03E8});
		end
		ask('{OP_CODE_Q, 8'h2E, 16'h0000}, '{OP_KP_WR, 8'h01, 16'h0000});
		wrap_up();
	end
endmodule
